// [rtl/uce_ctrl_ep.sv]
`timescale 1ns/100ps
`include "uce_consts.svh"
module uce_ctrl_ep #(
  parameter int DEPTH  = 8,
  parameter int NUM_EP = 6
)(
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // token side
  input  wire logic              addr_compare_en,
  input  wire logic              addr_match,
  input  wire logic              tok_valid,
  input  uce_pkg::uce_tok_t      tok_pid,
  input  wire logic [3:0]        tok_ep,
  input  wire logic              rx_byte_valid,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_end,
  input  wire logic              rx_ok,
  input  wire logic              rx_pid_data1,
  output logic                   tx_start,
  output logic                   tx_pid_data1,
  output logic                   tx_byte_valid,
  output logic      [7:0]        tx_payload_byte,
  input  wire logic              tx_byte_take,
  input  wire logic              tx_result_valid,
  input  wire logic              tx_result_ack,
  output logic                   hs_valid,
  output uce_pkg::uce_hs_t       hs_code,
  output logic                   def_addr_mode,
  output logic      [NUM_EP:1]   ep_hit,
  output logic      [NUM_EP:1]   ep_stall,
  output logic      [NUM_EP:1]   ep_no_nak
);
  if (NUM_EP < 1 || NUM_EP > 6)
  begin : g_chk
    $error("one to six extra endpoints");
  end

  uce_buf_if #(.W(8)) txb ();
  uce_buf_if #(.W(8)) rxb ();

  uce_buf #(.DEPTH(DEPTH), .W(8)) u_txbuf (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .bi(txb));
  uce_buf #(.DEPTH(DEPTH), .W(8)) u_rxbuf (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .bi(rxb));

  // ***************************************************************
  // bus slave
  // ***************************************************************
  logic                acc;
  logic                rd;
  logic [7:0]          a;
  logic                wr_pend_r;
  logic [7:0]          wr_addr_r;
  logic                wr;
  logic [7:0]          wd;
  logic                rd_txs;
  logic                rd_rxs;
  logic                rd_rxd;
  logic [7:0]          rd_val;
  logic [7:0]          epc_r [NUM_EP];
  logic                tx_en_r;
  logic                tx_tog_r;
  logic                ignore_in_tokens_r;
  logic                rx_en_r;
  logic                ignore_out_tokens_r;
  logic                ignore_setup_tokens_r;
  logic                flush_r;
  logic                stall0_r;
  logic                def_r;
  logic                tx_done_r;
  logic                ack_stat_r;
  logic                rx_last_r;
  logic                rx_tog_r;
  logic                setup_r;
  logic                zlp_pend_r;
  logic                hrd_upd;

  assign acc       = hsel && htrans[1] && hready;
  assign rd        = acc && !hwrite;
  assign a         = haddr[7:0];
  assign wr        = wr_pend_r;
  assign wd        = hwdata[7:0];
  assign rd_txs    = rd && a == `UCE_OFF_TXS;
  assign rd_rxs    = rd && a == `UCE_OFF_RXS;
  assign rd_rxd    = rd && a == `UCE_OFF_RXD;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrd_upd   = ce && rd;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= `UCE_RST_BYTE;
    end
    else if (ce)
    begin
      wr_pend_r <= acc && hwrite;
      wr_addr_r <= a;
    end
  end

  always_comb
  begin
    rd_val = `UCE_RST_BYTE;
    case (a)
      `UCE_OFF_TXS:
        rd_val = {1'b0, ack_stat_r, tx_done_r, 5'(DEPTH) - txb.count};
      `UCE_OFF_TXC:
        rd_val = {3'b000, ignore_in_tokens_r, flush_r, tx_tog_r, 1'b0, tx_en_r};
      `UCE_OFF_RXS:
        if (zlp_pend_r)
        begin
          rd_val = {3'b000, 1'b1, `UCE_CNT_ZERO};
        end
        else
        begin
          rd_val = {1'b0, setup_r, rx_tog_r, rx_last_r, rxb.count[3:0]};
        end
      `UCE_OFF_RXC:
        rd_val = {4'b0000, flush_r, ignore_setup_tokens_r, ignore_out_tokens_r, rx_en_r};
      `UCE_OFF_RXD:
        rd_val = rxb.empty ? `UCE_RST_BYTE : rxb.rdata;
      `UCE_OFF_ENDPOINT_ZERO_CONTROL:
        rd_val = {stall0_r, def_r, 2'b00, `UCE_EP_ZERO};
      default:
        for (int i = 0; i < NUM_EP; i++)
        begin
          if (a == `UCE_OFF_EPC1 + 8'(i) * `UCE_EPC_STEP)
          begin
            rd_val = epc_r[i];
          end
        end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hrdata <= '0;
    end
    else if (hrd_upd)
    begin
      hrdata <= {24'h000000, rd_val};
    end
  end

  // ***************************************************************
  // endpoints one to six
  // ***************************************************************
  for (genvar i = 0; i < NUM_EP; i++)
  begin : g_ep
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
      begin
        epc_r[i] <= `UCE_RST_BYTE;
      end
      else if (ce && wr && wr_addr_r == `UCE_OFF_EPC1 + 8'(i) * `UCE_EPC_STEP)
      begin
        epc_r[i] <= {wd[7], 1'b0, wd[5:0]};
      end
    end
    assign ep_hit[i+1]    = addr_compare_en && addr_match && epc_r[i][`UCE_EPC_EN]
                            && tok_ep == epc_r[i][3:0];
    assign ep_stall[i+1]  = epc_r[i][`UCE_EPC_STALL];
    assign ep_no_nak[i+1] = epc_r[i][`UCE_EPC_ISO];
  end

  // ***************************************************************
  // endpoint zero sequencing
  // ***************************************************************
  uce_pkg::uce_state_t st_r;
  logic                ep0_tok;
  logic                t_in;
  logic                t_out;
  logic                t_setup;
  logic                dup_r;
  logic                ovf_r;
  logic                rx_any_r;
  logic                stall_in;
  logic                stall_out;
  logic                sent_pkt;
  logic                rx_good;
  logic                rx_zlp;
  logic                flushing;

  assign ep0_tok   = tok_valid && addr_compare_en && addr_match && tok_ep == `UCE_EP_ZERO;
  assign t_in      = ep0_tok && tok_pid == uce_pkg::TOK_IN && !ignore_in_tokens_r && st_r == uce_pkg::ST_IDLE;
  assign t_out     = ep0_tok && tok_pid == uce_pkg::TOK_OUT && !ignore_out_tokens_r && st_r == uce_pkg::ST_IDLE;
  assign t_setup   = ep0_tok && tok_pid == uce_pkg::TOK_SETUP && !ignore_setup_tokens_r
                     && st_r == uce_pkg::ST_IDLE;
  assign stall_in  = t_in && stall0_r && tx_en_r && !rx_en_r;
  assign stall_out = t_out && stall0_r && rx_en_r;
  assign sent_pkt  = st_r == uce_pkg::ST_TX && tx_result_valid;
  assign rx_good   = rx_end && rx_ok && !ovf_r;
  assign rx_zlp    = !rx_any_r;
  assign flushing  = flush_r && st_r == uce_pkg::ST_IDLE;

  assign tx_pid_data1    = tx_tog_r;
  assign tx_byte_valid   = st_r == uce_pkg::ST_TX && !txb.empty;
  assign tx_payload_byte = txb.rdata;
  assign def_addr_mode   = def_r;

  assign txb.push  = ce && wr && wr_addr_r == `UCE_OFF_TXD;
  assign txb.wdata = wd;
  assign txb.pop   = ce && tx_byte_valid && tx_byte_take;
  assign txb.flush = flushing;
  assign rxb.push  = ce && rx_byte_valid && st_r inside {uce_pkg::ST_RX, uce_pkg::ST_RXSET};
  assign rxb.wdata = rx_byte;
  assign rxb.pop   = ce && rd_rxd;
  assign rxb.flush = flushing || (ce && t_setup && !dup_r);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r     <= uce_pkg::ST_IDLE;
      tx_start <= 1'b0;
      hs_valid <= 1'b0;
      hs_code  <= uce_pkg::HS_NAK;
    end
    else if (ce)
    begin
      tx_start <= 1'b0;
      hs_valid <= 1'b0;
      case (st_r)
        uce_pkg::ST_IDLE:
          if (stall_in || stall_out)
          begin
            hs_valid <= 1'b1;
            hs_code  <= uce_pkg::HS_STALL;
          end
          else if (t_in && tx_en_r && !rx_en_r)
          begin
            tx_start <= 1'b1;
            st_r     <= uce_pkg::ST_TX;
          end
          else if (t_in || (t_out && !rx_en_r))
          begin
            hs_valid <= 1'b1;
            hs_code  <= uce_pkg::HS_NAK;
          end
          else if (t_out)
          begin
            st_r <= uce_pkg::ST_RX;
          end
          else if (t_setup)
          begin
            st_r <= dup_r ? uce_pkg::ST_RXDUP : uce_pkg::ST_RXSET;
          end
        uce_pkg::ST_TX:
          if (tx_result_valid)
          begin
            st_r <= uce_pkg::ST_IDLE;
          end
        uce_pkg::ST_RX:
          if (rx_end)
          begin
            hs_valid <= rx_ok;
            hs_code  <= ovf_r ? uce_pkg::HS_NAK : uce_pkg::HS_ACK;
            st_r     <= uce_pkg::ST_IDLE;
          end
        uce_pkg::ST_RXSET, uce_pkg::ST_RXDUP:
          if (rx_end)
          begin
            hs_valid <= rx_good;
            hs_code  <= uce_pkg::HS_ACK;
            st_r     <= uce_pkg::ST_IDLE;
          end
        default:
          st_r <= uce_pkg::ST_IDLE;
      endcase
    end
  end

  // receive tracking, repeated setup
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovf_r    <= 1'b0;
      rx_any_r <= 1'b0;
      dup_r    <= 1'b0;
    end
    else if (ce)
    begin
      if (t_out || t_setup)
      begin
        ovf_r    <= 1'b0;
        rx_any_r <= 1'b0;
      end
      else if (rxb.push)
      begin
        rx_any_r <= 1'b1;
        ovf_r    <= ovf_r || rxb.full;
      end
      if (ep0_tok && tok_pid != uce_pkg::TOK_SETUP)
      begin
        dup_r <= 1'b0;
      end
      else if (st_r == uce_pkg::ST_RXSET && rx_good)
      begin
        dup_r <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // command registers
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_en_r     <= 1'b0;
      tx_tog_r    <= 1'b0;
      ignore_in_tokens_r    <= 1'b0;
      rx_en_r     <= 1'b0;
      ignore_out_tokens_r   <= 1'b0;
      ignore_setup_tokens_r <= 1'b0;
      flush_r     <= 1'b0;
      stall0_r    <= 1'b0;
      def_r       <= 1'b0;
    end
    else if (ce)
    begin
      if (sent_pkt || stall_in)
      begin
        tx_en_r <= 1'b0;
      end
      if ((st_r == uce_pkg::ST_RX && rx_good) || stall_out)
      begin
        rx_en_r <= 1'b0;
      end
      if (sent_pkt)
      begin
        def_r <= 1'b0;
      end
      if (flushing)
      begin
        flush_r <= 1'b0;
      end
      if (wr && wr_addr_r == `UCE_OFF_TXC)
      begin
        tx_en_r  <= wd[`UCE_TXC_EN];
        tx_tog_r <= wd[`UCE_TXC_TOG];
        ignore_in_tokens_r <= wd[`UCE_TXC_IGN];
        flush_r  <= (flush_r && !flushing) || wd[`UCE_TXC_FLUSH];
      end
      if (wr && wr_addr_r == `UCE_OFF_RXC)
      begin
        rx_en_r     <= wd[`UCE_RXC_EN];
        ignore_out_tokens_r   <= wd[`UCE_RXC_IGNO];
        ignore_setup_tokens_r <= wd[`UCE_RXC_IGNS];
        flush_r     <= (flush_r && !flushing) || wd[`UCE_RXC_FLUSH];
      end
      if (wr && wr_addr_r == `UCE_OFF_ENDPOINT_ZERO_CONTROL)
      begin
        stall0_r <= wd[`UCE_EPC_STALL];
        def_r    <= wd[`UCE_EPC_DEF];
      end
    end
  end

  // ***************************************************************
  // status flags, set wins over read clear
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_done_r  <= 1'b0;
      ack_stat_r <= 1'b0;
    end
    else if (ce)
    begin
      if (sent_pkt || stall_in)
      begin
        tx_done_r  <= 1'b1;
        ack_stat_r <= sent_pkt && tx_result_ack;
      end
      else if (rd_txs)
      begin
        tx_done_r  <= 1'b0;
        ack_stat_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_last_r  <= 1'b0;
      rx_tog_r   <= 1'b0;
      setup_r    <= 1'b0;
      zlp_pend_r <= 1'b0;
    end
    else if (ce)
    begin
      if (rd_rxs && zlp_pend_r)
      begin
        zlp_pend_r <= 1'b0;
      end
      else if (rd_rxs)
      begin
        rx_last_r <= 1'b0;
        rx_tog_r  <= 1'b0;
        setup_r   <= 1'b0;
      end
      if (stall_out)
      begin
        rx_last_r <= 1'b1;
      end
      if (rx_good && rx_zlp && st_r inside {uce_pkg::ST_RX, uce_pkg::ST_RXSET})
      begin
        zlp_pend_r <= 1'b1;
      end
      else if (rx_good && st_r inside {uce_pkg::ST_RX, uce_pkg::ST_RXSET})
      begin
        rx_last_r <= 1'b1;
        rx_tog_r  <= rx_pid_data1;
        setup_r   <= st_r == uce_pkg::ST_RXSET || setup_r;
      end
    end
  end
endmodule : uce_ctrl_ep

// [shared/uce_consts.svh]
`ifndef UCE_CONSTS_SVH
`define UCE_CONSTS_SVH
// Notes on behaviour
// - stall: IN gets STALL if transmit enabled and receive disabled, OUT if receive enabled.
// - SETUP is never answered with STALL.
// - a STALL sets receive-last or transmit-done.
// - transmit status 4..0: free buffer bytes, at most 8.
// - transmit-done set at packet end, cleared by read.
// - ack status set on host ACK, else clear; read clears.
// - firmware sets transmit-enable; cleared after one packet or STALL.
// - transmit-enable ignored while receive-enable set.
// - transmit-enable on empty buffer sends zero-length packet.
// - transmit toggle picks DATA0/DATA1; hardware never changes it.
// - flush waits for idle endpoint, empties buffers, self-clears after transfer end.
// - ignore bits silently drop IN, OUT or SETUP tokens.
// - firmware writes payload only; PID and CRC16 added outside.
// - receive data is payload only; PID and CRC16 stripped outside.
// - two receive status copies: zero-length status read first, then SETUP.
// - receive status 3..0: bytes in buffer, at most 8.
// - receive-last set on ACKed reception; zero-length keeps it; read clears.
// - received toggle holds last good data PID; zero-length keeps it; read clears.
// - setup flag set on SETUP; zero-length keeps it; read clears.
// - receive-enable clears per ACKed OUT packet or OUT STALL; SETUP taken even with it clear.
// - repeated SETUP discarded and ACKed; other refused SETUP gets no handshake.
// - endpoints 1..6 match when enabled and compare on; ISO never NAKs.

// register byte offsets
`define UCE_OFF_TXS   8'h00
`define UCE_OFF_TXC   8'h04
`define UCE_OFF_TXD   8'h08
`define UCE_OFF_RXS   8'h0C
`define UCE_OFF_RXC   8'h10
`define UCE_OFF_RXD   8'h14
`define UCE_OFF_ENDPOINT_ZERO_CONTROL  8'h18
`define UCE_OFF_EPC1  8'h1C
`define UCE_EPC_STEP  8'h04
// field positions
`define UCE_TXS_ACK   6
`define UCE_TXS_DONE  5
`define UCE_TXC_IGN   4
`define UCE_TXC_FLUSH 3
`define UCE_TXC_TOG   2
`define UCE_TXC_EN    0
`define UCE_RXS_SETUP 6
`define UCE_RXS_TOG   5
`define UCE_RXS_LAST  4
`define UCE_RXC_FLUSH 3
`define UCE_RXC_IGNS  2
`define UCE_RXC_IGNO  1
`define UCE_RXC_EN    0
`define UCE_EPC_STALL 7
`define UCE_EPC_DEF   6
`define UCE_EPC_ISO   5
`define UCE_EPC_EN    4
// reset values
`define UCE_RST_BYTE  8'h00
`define UCE_EP_ZERO   4'h0
`define UCE_CNT_ZERO  4'h0
`endif

// [shared/uce_pkg.sv]
package uce_pkg;
  typedef enum logic [1:0] {TOK_OUT = 2'b00, TOK_IN = 2'b01, TOK_SETUP = 2'b10} uce_tok_t;
  typedef enum logic [1:0] {HS_ACK = 2'b00, HS_NAK = 2'b01, HS_STALL = 2'b10} uce_hs_t;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_TX    = 3'b001,
    ST_RX    = 3'b010,
    ST_RXSET = 3'b011,
    ST_RXDUP = 3'b100
  } uce_state_t;
endpackage : uce_pkg

// [shared/uce_buf_if.sv]
`timescale 1ns/100ps
interface uce_buf_if #(parameter int W = 8);
  logic         push;
  logic         pop;
  logic         flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [4:0]   count;
  logic         full;
  logic         empty;
  modport owner (output push, pop, flush, wdata, input rdata, count, full, empty);
  modport fifo  (input push, pop, flush, wdata, output rdata, count, full, empty);
endinterface : uce_buf_if

// [rtl/uce_buf.sv]
`timescale 1ns/100ps
module uce_buf #(
  parameter int DEPTH = 8,
  parameter int W     = 8
)(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ce,
  uce_buf_if.fifo  bi
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   n_r;
  logic          do_push;
  logic          do_pop;

  if (DEPTH < 2 || DEPTH > 8 || DEPTH != (1 << AW))
  begin : g_chk
    $error("buffer depth must be 2, 4 or 8");
  end

  assign do_push  = bi.push && !bi.full;
  assign do_pop   = bi.pop && !bi.empty;
  assign bi.rdata = mem[rp_r];
  assign bi.count = 5'(n_r);
  assign bi.full  = n_r == (AW+1)'(DEPTH);
  assign bi.empty = n_r == '0;

  always_ff @(posedge clk_sys)
  begin
    if (ce && do_push && !bi.flush)
    begin
      mem[wp_r] <= bi.wdata;
    end
  end

  // flush zeroes pointers and count
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      n_r  <= '0;
    end
    else if (ce)
    begin
      if (bi.flush)
      begin
        wp_r <= '0;
        rp_r <= '0;
        n_r  <= '0;
      end
      else
      begin
        if (do_push)
        begin
          wp_r <= wp_r + 1'b1;
        end
        if (do_pop)
        begin
          rp_r <= rp_r + 1'b1;
        end
        n_r <= n_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
    end
  end
endmodule : uce_buf

// [verif/uce_ctrl_ep_chk.sv]
`timescale 1ns/100ps
module uce_ctrl_ep_chk #(
  parameter int NUM_EP = 6
)(
  input wire logic          clk_sys,
  input wire logic          reset_n,
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic          hreadyout,
  input wire logic          hresp,
  input wire logic          addr_compare_en,
  input wire logic          tok_valid,
  input uce_pkg::uce_tok_t  tok_pid,
  input wire logic          rx_end,
  input wire logic          rx_ok,
  input wire logic          tx_start,
  input wire logic          tx_pid_data1,
  input wire logic          hs_valid,
  input uce_pkg::uce_hs_t   hs_code,
  input wire logic [NUM_EP:1] ep_hit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_bus_ok; hreadyout && !hresp; endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus not ready or not okay");
  property p_hs_cause; hs_valid |-> $past(tok_valid) || $past(rx_end); endproperty
  a_hs_cause: assert property (p_hs_cause)
    else $error("handshake without token or packet");
  property p_setup_nostall; tok_valid && tok_pid == uce_pkg::TOK_SETUP |=> !(hs_valid && hs_code == uce_pkg::HS_STALL);
  endproperty
  a_setup_nostall: assert property (p_setup_nostall)
    else $error("stall after setup token");
  property p_bad_nohs; rx_end && !rx_ok |=> !hs_valid ##1 !hs_valid; endproperty
  a_bad_nohs: assert property (p_bad_nohs)
    else $error("handshake after bad packet");
  property p_tx_in; tx_start |-> $past(tok_valid && tok_pid == uce_pkg::TOK_IN); endproperty
  a_tx_in: assert property (p_tx_in)
    else $error("data packet without in token");
  property p_tog_hold; $changed(tx_pid_data1) |-> $past(hsel && htrans[1] && hwrite && haddr[7:0] == 8'h04, 2);
  endproperty
  a_tog_hold: assert property (p_tog_hold)
    else $error("toggle changed without write");
  property p_no_cmp; !addr_compare_en |-> ep_hit == '0; endproperty
  a_no_cmp: assert property (p_no_cmp)
    else $error("endpoint hit with compare off");
  property p_stall_tok; hs_valid && hs_code == uce_pkg::HS_STALL |-> $past(tok_valid && tok_pid != uce_pkg::TOK_SETUP);
  endproperty
  a_stall_tok: assert property (p_stall_tok)
    else $error("stall without in or out token");
  c_tx: cover property (tx_start);
  c_stall: cover property (hs_valid && hs_code == uce_pkg::HS_STALL);
  c_ack: cover property (hs_valid && hs_code == uce_pkg::HS_ACK);
endmodule : uce_ctrl_ep_chk
bind uce_ctrl_ep uce_ctrl_ep_chk #(.NUM_EP(NUM_EP)) u_chk (.*);

// [verif/uce_host_model.sv]
`timescale 1ns/100ps
module uce_host_model (
  input  wire logic        clk_sys,
  output logic             tok_valid,
  output uce_pkg::uce_tok_t tok_pid,
  output logic [3:0]       tok_ep,
  output logic             rx_byte_valid,
  output logic [7:0]       rx_byte,
  output logic             rx_end,
  output logic             rx_ok,
  output logic             rx_pid_data1,
  input  wire logic        tx_start,
  input  wire logic        tx_byte_valid,
  input  wire logic [7:0]  tx_payload_byte,
  output logic             tx_byte_take,
  output logic             tx_result_valid,
  output logic             tx_result_ack
);
  logic [7:0] got[$];
  logic       busy_r;
  int         n_done;
  initial
  begin
    {tok_valid, rx_byte_valid, rx_end, rx_ok, rx_pid_data1} = 5'h00;
    {tx_byte_take, tx_result_valid, tx_result_ack, busy_r} = 4'h0;
    tok_pid = uce_pkg::TOK_OUT;
    tok_ep = 4'hF;
    rx_byte = 8'h00;
    n_done = 0;
  end
  // ****************************
  // in data: take bytes, then ack
  // ****************************
  always @(posedge clk_sys)
  begin
    tx_result_valid <= 1'b0;
    if (tx_start)
      busy_r <= 1'b1;
    else if (busy_r && tx_byte_take)
      tx_byte_take <= 1'b0;
    else if (busy_r && tx_byte_valid)
    begin
      tx_byte_take <= 1'b1;
      got.push_back(tx_payload_byte);
    end
    else if (busy_r)
    begin
      tx_result_valid <= 1'b1;
      tx_result_ack <= 1'b1;
      busy_r <= 1'b0;
      n_done <= n_done + 1;
    end
  end
  task automatic token(input uce_pkg::uce_tok_t p);
    @(posedge clk_sys);
    tok_valid <= 1'b1;
    tok_pid <= p;
    tok_ep <= 4'h0;
    @(posedge clk_sys);
    tok_valid <= 1'b0;
    tok_ep <= 4'hF;
  endtask : token
  // payload only
  task automatic packet(input int n, input logic d1, input logic ok);
    for (int i = 0; i < n; i++)
    begin
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'hA0 + 8'(i);
      @(posedge clk_sys);
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_end <= 1'b1;
    rx_ok <= ok;
    rx_pid_data1 <= d1;
    @(posedge clk_sys);
    rx_end <= 1'b0;
    rx_ok <= ~ok;
  endtask : packet
endmodule : uce_host_model

// [verif/tb.sv]
`timescale 1ns/100ps
`include "uce_consts.svh"
module tb;
  localparam int DEPTH = 8;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} uce_row_t;
  logic clk_sys, reset_n, hsel, hwrite, hreadyout, hresp, addr_compare_en, tok_valid, rx_byte_valid, rx_end;
  logic rx_ok, rx_pid_data1, tx_start, tx_pid_data1, tx_byte_valid, tx_byte_take, tx_result_valid;
  logic tx_result_ack, hs_valid, def_addr_mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] tok_ep;
  logic [7:0] rx_byte, tx_payload_byte;
  logic [6:1] ep_hit, ep_stall, ep_no_nak;
  uce_pkg::uce_tok_t tok_pid;
  uce_pkg::uce_hs_t  hs_code, hs_got;
  int miscompares, n_compared, hs_cnt, n0;
  uce_row_t rows[8] = '{'{8'h1C, 32'hFF, 32'hBF}, '{8'h20, 32'h35, 32'h35}, '{8'h18, 32'hFF, 32'hC0},
    '{8'h18, 32'h00, 32'h00}, '{8'h40, 32'hFF, 32'h00}, '{8'h10, 32'h06, 32'h06}, '{8'h10, 32'h00, 32'h00},
    '{8'h04, 32'h14, 32'h14}};
  uce_ctrl_ep #(.DEPTH(DEPTH), .NUM_EP(6)) dut (.clk_sys, .reset_n, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .addr_compare_en, .addr_match(1'b1),
    .tok_valid, .tok_pid, .tok_ep, .rx_byte_valid, .rx_byte, .rx_end, .rx_ok, .rx_pid_data1, .tx_start,
    .tx_pid_data1, .tx_byte_valid, .tx_payload_byte, .tx_byte_take, .tx_result_valid, .tx_result_ack, .hs_valid,
    .hs_code, .def_addr_mode, .ep_hit, .ep_stall, .ep_no_nak);
  uce_host_model host (.clk_sys, .tok_valid, .tok_pid, .tok_ep, .rx_byte_valid, .rx_byte, .rx_end, .rx_ok,
    .rx_pid_data1, .tx_start, .tx_byte_valid, .tx_payload_byte, .tx_byte_take, .tx_result_valid, .tx_result_ack);
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (hs_valid === 1'b1)
    begin
      hs_cnt <= hs_cnt + 1;
      hs_got <= hs_code;
    end
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        miscompares++;
        wrap_up;
      end
      @(posedge clk_sys);
    end
  endtask : wait_rdy
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, e);
  endtask : rd_chk
  task automatic expect_hs(input logic any, input uce_pkg::uce_hs_t c);
    int h0;
    h0 = hs_cnt;
    repeat (8) @(posedge clk_sys);
    check(32'(hs_cnt - h0), {31'h0, any});
    if (any)
      check(32'(hs_got), 32'(c));
  endtask : expect_hs
  task automatic in_xfer;
    int n;
    n0 = host.n_done;
    host.token(uce_pkg::TOK_IN);
    for (n = 0; n < 60 && host.n_done == n0; n++)
      @(posedge clk_sys);
    check(32'(host.n_done - n0), 32'h1);
  endtask : in_xfer
  initial
  begin
    {clk_sys, reset_n, hsel, hwrite, addr_compare_en} = 5'h00;
    {haddr, hwdata, htrans, hsize} = 69'h2;
    {miscompares, n_compared, hs_cnt} = 96'h0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    addr_compare_en <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd_chk(8'(4 * i), i == 0 ? 32'(DEPTH) : 32'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e);
    end
    check(32'({ep_stall, ep_no_nak}), 32'h043);
    wr(`UCE_OFF_TXC, 32'h0);
    wr(`UCE_OFF_RXC, 32'h1);
    host.token(uce_pkg::TOK_OUT);
    host.packet(3, 1'b1, 1'b1);
    expect_hs(1'b1, uce_pkg::HS_ACK);
    rd_chk(`UCE_OFF_RXS, 32'h33);
    rd_chk(`UCE_OFF_RXS, 32'h03);
    for (int i = 0; i < 3; i++)
      rd_chk(`UCE_OFF_RXD, 32'hA0 + i);
    rd_chk(`UCE_OFF_RXC, 32'h0);
    wr(`UCE_OFF_TXD, 32'h5A);
    wr(`UCE_OFF_TXD, 32'hC3);
    rd_chk(`UCE_OFF_TXS, DEPTH - 2);
    wr(`UCE_OFF_TXC, 32'h5);
    in_xfer;
    check({host.got[0], host.got[1]}, 32'h5AC3);
    rd_chk(`UCE_OFF_TXS, 32'h60 | DEPTH);
    rd_chk(`UCE_OFF_TXS, DEPTH);
    rd_chk(`UCE_OFF_TXC, 32'h4);
    wr(`UCE_OFF_TXC, 32'h1);
    in_xfer;
    check(32'(host.got.size()), 32'h2);
    wr(`UCE_OFF_RXC, 32'h1);
    wr(`UCE_OFF_TXC, 32'h1);
    host.token(uce_pkg::TOK_IN);
    expect_hs(1'b1, uce_pkg::HS_NAK);
    wr(`UCE_OFF_ENDPOINT_ZERO_CONTROL, 32'h80);
    host.token(uce_pkg::TOK_OUT);
    expect_hs(1'b1, uce_pkg::HS_STALL);
    rd_chk(`UCE_OFF_RXS, 32'h10);
    rd_chk(`UCE_OFF_RXC, 32'h0);
    host.token(uce_pkg::TOK_IN);
    expect_hs(1'b1, uce_pkg::HS_STALL);
    rd_chk(`UCE_OFF_TXS, 32'h20 | DEPTH);
    rd_chk(`UCE_OFF_TXC, 32'h0);
    host.token(uce_pkg::TOK_SETUP);
    host.packet(8, 1'b0, 1'b1);
    expect_hs(1'b1, uce_pkg::HS_ACK);
    rd_chk(`UCE_OFF_RXS, 32'h58);
    host.token(uce_pkg::TOK_SETUP);
    host.packet(2, 1'b0, 1'b1);
    expect_hs(1'b1, uce_pkg::HS_ACK);
    host.token(uce_pkg::TOK_SETUP);
    host.packet(2, 1'b0, 1'b0);
    expect_hs(1'b0, uce_pkg::HS_ACK);
    wr(`UCE_OFF_ENDPOINT_ZERO_CONTROL, 32'h0);
    wr(`UCE_OFF_RXC, 32'h7);
    wr(`UCE_OFF_TXC, 32'h10);
    n0 = hs_cnt;
    host.token(uce_pkg::TOK_OUT);
    host.packet(1, 1'b0, 1'b1);
    host.token(uce_pkg::TOK_SETUP);
    host.packet(1, 1'b0, 1'b1);
    host.token(uce_pkg::TOK_IN);
    expect_hs(1'b0, uce_pkg::HS_ACK);
    check(32'(hs_cnt - n0), 32'h0);
    wr(`UCE_OFF_RXC, 32'h0);
    wr(`UCE_OFF_TXC, 32'h0);
    wr(`UCE_OFF_TXD, 32'h11);
    wr(`UCE_OFF_TXC, 32'h8);
    rd_chk(`UCE_OFF_TXC, 32'h8);
    rd_chk(`UCE_OFF_TXS, DEPTH);
    rd_chk(`UCE_OFF_TXC, 32'h0);
    wrap_up;
  end
endmodule : tb
